// *** ulam_pkg.sv ***
// constants shared by the unstructured leased line alarm mapper
//----------------------------------------------------------------------
// Operation
// RL1: the access section is operational only when every pair is activated, every pair id is correct and no other failure is seen.
// RL2: any single pair that is not operational or has a wrong id makes the access section non-operational.
// RL3: the 2048 kbit/s payload is carried untouched, no maintenance data is put into or taken from it.
// RL4: loss of signal at the application input sends a continuous all-ones payload to the far end.
// RL5: the loss indicator at overhead bit 15 goes to zero at the same moment the all-ones payload starts.
// RL6: loss at this unit's input clears the loss indicator in the overhead sent from this unit to its peer.
// RL7: loss of signal or frame alignment on any pair or regenerator side makes the line-side unit output an alarm.
// RL8: until every transceiver is fully active the customer-side output is unconstrained.
// RL9: the mean one-way delay over both directions stays within 1250 us.
// RL10: each termination unit adds at most 450 us of delay.
// RL11: the free-running interface timing is 2048 kHz within 50 ppm.
// RL12: an input stream offset by up to 50 ppm from nominal is carried without bit errors.
// RL13: application data is mapped into a 144-byte core frame every 500 us, 128 bytes of it payload.
// RL14: the 16 stuffing bytes of each core frame are all ones.
// RL15: the unused overhead bits 9 to 48 are sent as ones.
// RL16: the alarm at the application interface is a continuous all-ones stream at the interface rate.
//----------------------------------------------------------------------
package ulam_pkg;
   localparam int CLK_NS = 40;
   localparam longint SYS_HZ = 25000000;
   localparam longint APP_HZ = 2048000;
   localparam logic [63:0] PHASE_INC64 = (64'(APP_HZ) << 32) / 64'(SYS_HZ);
   localparam logic [31:0] PHASE_INC = PHASE_INC64[31:0];
   localparam int FRAME_US = 500;
   localparam int FRAME_BYTES = 144;
   localparam int STUFF_PERIOD = 9;
   localparam int OH_BITS = 48;
   localparam int LOSD_BIT = 15;
   localparam int OH_FREE_LO = 9;
   localparam int LOS_NS = 8000;
   localparam int LOS_CYC = (LOS_NS + CLK_NS - 1) / CLK_NS;
   localparam int TERM_DELAY_US = 450;
   localparam int TERM_DELAY_CYC = TERM_DELAY_US * 1000 / CLK_NS;
   localparam int BYTE_W = 8;
   localparam int FIFO_DEPTH = 8;
   localparam logic [7:0] BYTE_ONES = 8'hff;
   typedef enum logic {ULAM_FR_SEND = 1'b0, ULAM_FR_GAP = 1'b1} ulam_frame_t;
endpackage : ulam_pkg

// *** ulam_mapper.sv ***
// byte fifo and the alarm mapper top for the unstructured 2 Mbit/s line
//----------------------------------------------------------------------
// fifo
//----------------------------------------------------------------------
module ulam_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data,
   // fill level
   output logic [$clog2(D):0] count
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;

   // handshake terms
   assign in_ready = (cnt_r != (AW+1)'(D));
   assign out_valid = (cnt_r != '0);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rp_r];
   assign count = cnt_r;

   // storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end

   // pointers and level
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : ulam_fifo

//----------------------------------------------------------------------
// mapper top
//----------------------------------------------------------------------
module ulam_mapper #(
   parameter int NPAIRS = 2,
   parameter int FRAME_CYC = ulam_pkg::FRAME_US * 1000 / ulam_pkg::CLK_NS
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // unit role
   input wire logic line_side,
   // application input pins
   input wire logic app_rx_clk,
   input wire logic app_rx_data,
   // application output
   output logic app_tx_clk,
   output logic app_tx_data,
   // pair status from the transceivers
   input wire logic [NPAIRS-1:0] pair_active,
   input wire logic [NPAIRS-1:0] pair_id_ok,
   input wire logic [NPAIRS-1:0] pair_los,
   input wire logic [NPAIRS-1:0] pair_frame_alignment_loss,
   input wire logic far_los_or_lfa,
   input wire logic other_fail,
   // core frame towards the transceivers
   output logic [7:0] core_tx_byte,
   output logic core_tx_valid,
   output logic core_tx_sof,
   output logic [ulam_pkg::OH_BITS:1] core_tx_line_frame_overhead,
   // payload bytes from the transceivers
   input wire logic [7:0] core_rx_byte,
   input wire logic core_rx_valid,
   output logic core_rx_ready,
   // status
   output logic access_oper,
   output logic app_los,
   output logic alarm_indication_signal
);
   localparam int SLOT_CYC = FRAME_CYC / ulam_pkg::FRAME_BYTES;
   localparam int FW = $clog2(FRAME_CYC);
   localparam int SW = $clog2(SLOT_CYC);
   localparam int CW = $clog2(ulam_pkg::FIFO_DEPTH) + 1;
   localparam int DLY = ulam_pkg::TERM_DELAY_CYC;

   logic [2:0] aclk_s_r;
   logic [2:0] adat_s_r;
   logic aclk_lvl_r;
   logic rise;
   logic [15:0] los_cnt_r;
   logic los_r;
   logic [2:0] bit_cnt_r;
   logic [7:0] sh_r;
   logic pend_r;
   logic [7:0] pbyte_r;
   logic done;
   logic tx_in_ready;
   logic tx_out_valid;
   logic tx_out_ready;
   logic [7:0] tx_out_data;
   logic [FW-1:0] fcnt_r;
   logic [SW-1:0] slot_r;
   logic [7:0] bidx_r;
   logic [3:0] sub_r;
   ulam_pkg::ulam_frame_t state_r;
   logic fwrap;
   logic tick;
   logic stuff;
   logic oper_r;
   logic alarm_r;
   logic ais_r;
   logic [CW-1:0] rx_cnt;
   logic rx_out_valid;
   logic rx_out_ready;
   logic [7:0] rx_out_data;
   logic rx_ready_r;
   logic [31:0] acc_r;
   logic aclk_out_r;
   logic btick;
   logic [2:0] rbit_r;
   logic [7:0] rsh_r;
   logic rhave_r;
   logic nbit;
   logic adat_r;
   logic [15:0] wait_r;

   //-------------------------------------------------------------------
   // application input capture
   //-------------------------------------------------------------------
   // three-stage synchronisers on the input pins
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         aclk_s_r <= '0;
         adat_s_r <= '0;
         aclk_lvl_r <= 1'b0;
      end else begin
         aclk_s_r <= {aclk_s_r[1:0], app_rx_clk};
         adat_s_r <= {adat_s_r[1:0], app_rx_data};
         if (aclk_s_r[1] == aclk_s_r[2]) begin
            aclk_lvl_r <= aclk_s_r[2];
         end
      end
   end
   // rising edge only once stages two and three agree
   assign rise = (aclk_s_r[1] == aclk_s_r[2]) & aclk_s_r[2] & ~aclk_lvl_r;

   // loss of signal: no input clock edge for the loss time
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         los_cnt_r <= '0;
         los_r <= 1'b1;
      end else if (rise) begin
         los_cnt_r <= '0;
         los_r <= 1'b0;
      end else if (los_cnt_r < 16'(ulam_pkg::LOS_CYC)) begin
         los_cnt_r <= los_cnt_r + 1'b1;
      end else begin
         los_r <= 1'b1;
      end
   end

   // bit to byte assembly, edge driven so rate offset needs no retiming
   assign done = rise & (bit_cnt_r == 3'h7);
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         bit_cnt_r <= '0;
         sh_r <= '0;
         pend_r <= 1'b0;
         pbyte_r <= '0;
      end else begin
         if (rise) begin
            sh_r <= {sh_r[6:0], adat_s_r[2]};
            bit_cnt_r <= bit_cnt_r + 1'b1; // RL12
         end
         if (done && (!pend_r || tx_in_ready)) begin
            pbyte_r <= {sh_r[6:0], adat_s_r[2]}; // RL3
         end
         pend_r <= (pend_r & ~tx_in_ready) | done;
      end
   end

   // transmit byte buffer, the frame builder stalls it
   ulam_fifo #(.W(ulam_pkg::BYTE_W), .D(ulam_pkg::FIFO_DEPTH)) u_tx_fifo (
      .clk(sys_clk),
      .resetn(resetn),
      .in_valid(pend_r),
      .in_ready(tx_in_ready),
      .in_data(pbyte_r),
      .out_valid(tx_out_valid),
      .out_ready(tx_out_ready),
      .out_data(tx_out_data),
      .count()
   );

   //-------------------------------------------------------------------
   // core frame builder
   //-------------------------------------------------------------------
   assign fwrap = (fcnt_r == FW'(FRAME_CYC - 1));
   assign tick = (state_r == ulam_pkg::ULAM_FR_SEND) &&
                 (slot_r == SW'(SLOT_CYC - 1));
   assign stuff = (sub_r == 4'(ulam_pkg::STUFF_PERIOD - 1));
   assign tx_out_ready = tick & ~stuff;

   // frame period, byte slots and byte index
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         fcnt_r <= '0;
         slot_r <= '0;
         bidx_r <= '0;
         sub_r <= '0;
         state_r <= ulam_pkg::ULAM_FR_SEND;
      end else begin
         fcnt_r <= fwrap ? '0 : fcnt_r + 1'b1;
         slot_r <= (fwrap || slot_r == SW'(SLOT_CYC - 1)) ? '0 : slot_r + 1'b1;
         if (fwrap) begin
            bidx_r <= '0;
            sub_r <= '0;
            state_r <= ulam_pkg::ULAM_FR_SEND;
         end else if (tick) begin
            bidx_r <= bidx_r + 1'b1; // RL13
            sub_r <= stuff ? '0 : sub_r + 1'b1;
            case (state_r)
               ulam_pkg::ULAM_FR_SEND: begin
                  if (bidx_r == 8'(ulam_pkg::FRAME_BYTES - 1)) begin
                     state_r <= ulam_pkg::ULAM_FR_GAP;
                  end
               end
               default: begin
                  state_r <= ulam_pkg::ULAM_FR_GAP;
               end
            endcase
         end
      end
   end

   // byte selection: stuffing, loss fill or payload
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         core_tx_byte <= ulam_pkg::BYTE_ONES;
         core_tx_valid <= 1'b0;
         core_tx_sof <= 1'b0;
      end else begin
         core_tx_valid <= tick;
         core_tx_sof <= tick && (bidx_r == '0);
         if (tick) begin
            if (stuff) begin
               core_tx_byte <= ulam_pkg::BYTE_ONES; // RL14
            end else if (los_r || !tx_out_valid) begin
               core_tx_byte <= ulam_pkg::BYTE_ONES; // RL4
            end else begin
               core_tx_byte <= tx_out_data; // RL3
            end
         end
      end
   end

   // overhead: unused bits ones, loss indicator low while input is lost
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         core_tx_line_frame_overhead <= '1;
      end else begin
         core_tx_line_frame_overhead <= '1; // RL15
         core_tx_line_frame_overhead[ulam_pkg::LOSD_BIT] <= ~los_r; // RL5 RL6
      end
   end

   // how long the head byte waits for a slot
   always_ff @(posedge sys_clk) begin
      if (!resetn || !tx_out_valid || tx_out_ready) begin
         wait_r <= '0;
      end else begin
         wait_r <= wait_r + 1'b1;
      end
   end

   //-------------------------------------------------------------------
   // maintenance state
   //-------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         oper_r <= 1'b0;
         alarm_r <= 1'b0;
         ais_r <= 1'b0;
      end else begin
         oper_r <= (&pair_active) & (&pair_id_ok) & ~other_fail; // RL1 RL2
         alarm_r <= (|pair_los) | (|pair_frame_alignment_loss) |
                    far_los_or_lfa;
         ais_r <= line_side & alarm_r; // RL7
      end
   end
   assign access_oper = oper_r;
   assign app_los = los_r;
   assign alarm_indication_signal = ais_r;

   //-------------------------------------------------------------------
   // receive path towards the application interface
   //-------------------------------------------------------------------
   ulam_fifo #(.W(ulam_pkg::BYTE_W), .D(ulam_pkg::FIFO_DEPTH)) u_rx_fifo (
      .clk(sys_clk),
      .resetn(resetn),
      .in_valid(core_rx_valid),
      .in_ready(),
      .in_data(core_rx_byte),
      .out_valid(rx_out_valid),
      .out_ready(rx_out_ready),
      .out_data(rx_out_data),
      .count(rx_cnt)
   );

   // registered ready leaves one word of slack for the late push
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         rx_ready_r <= 1'b0;
      end else begin
         rx_ready_r <= (rx_cnt <= CW'(ulam_pkg::FIFO_DEPTH - 2));
      end
   end
   assign core_rx_ready = rx_ready_r;

   // fractional divider for the free-running 2048 kHz interface clock
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         acc_r <= '0;
         aclk_out_r <= 1'b0;
      end else begin
         acc_r <= acc_r + ulam_pkg::PHASE_INC; // RL11
         aclk_out_r <= acc_r[31];
      end
   end
   assign btick = acc_r[31] & ~aclk_out_r;
   assign app_tx_clk = aclk_out_r;
   assign rx_out_ready = btick && (rbit_r == '0);
   assign nbit = (rbit_r == '0) ? (rx_out_valid ? rx_out_data[7] : 1'b1) :
                 (rhave_r ? rsh_r[7] : 1'b1);

   // byte to bit serialiser, alarm forces all ones
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         rbit_r <= '0;
         rsh_r <= '1;
         rhave_r <= 1'b0;
         adat_r <= 1'b1;
      end else if (btick) begin
         rbit_r <= rbit_r + 1'b1;
         if (rbit_r == '0) begin
            rsh_r <= {rx_out_data[6:0], 1'b1};
            rhave_r <= rx_out_valid;
         end else begin
            rsh_r <= {rsh_r[6:0], 1'b1};
         end
         adat_r <= (ais_r || !oper_r) ? 1'b1 : nbit; // RL16 RL8
      end
   end
   assign app_tx_data = adat_r;

   //-------------------------------------------------------------------
   // checks
   //-------------------------------------------------------------------
   AST_OPER_UP: assert property (@(posedge sys_clk) disable iff (!resetn)
      (&pair_active && &pair_id_ok && !other_fail) |=> access_oper)
      else $error("section not operational with all pairs good"); // RL1
   AST_OPER_DOWN: assert property (@(posedge sys_clk) disable iff (!resetn)
      (!(&pair_active) || !(&pair_id_ok)) |=> !access_oper)
      else $error("section operational with a bad pair"); // RL2
   AST_PASS: assert property (@(posedge sys_clk) disable iff (!resetn)
      (tick && !stuff && !los_r && tx_out_valid) |=>
      (core_tx_valid && core_tx_byte == $past(tx_out_data)))
      else $error("payload byte altered"); // RL3
   AST_LOS_ONES: assert property (@(posedge sys_clk) disable iff (!resetn)
      (tick && los_r) |=> (core_tx_byte == ulam_pkg::BYTE_ONES))
      else $error("payload not all ones during loss"); // RL4
   AST_LOSD: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(los_r) |=> (!core_tx_line_frame_overhead[ulam_pkg::LOSD_BIT]
      ##1 !core_tx_line_frame_overhead[ulam_pkg::LOSD_BIT]))
      else $error("loss indicator not cleared with loss"); // RL5
   AST_AIS: assert property (@(posedge sys_clk) disable iff (!resetn)
      (line_side && |pair_los) |=> ##1 alarm_indication_signal)
      else $error("alarm not raised on pair loss"); // RL7
   AST_AIS_ONES: assert property (@(posedge sys_clk) disable iff (!resetn)
      (ais_r && btick) |=> app_tx_data)
      else $error("alarm stream not all ones"); // RL16
   AST_STUFF: assert property (@(posedge sys_clk) disable iff (!resetn)
      (tick && stuff) |=> (core_tx_byte == ulam_pkg::BYTE_ONES))
      else $error("stuffing byte not all ones"); // RL14
   AST_OH: assert property (@(posedge sys_clk) disable iff (!resetn)
      ##1 (&core_tx_line_frame_overhead[ulam_pkg::OH_BITS:
      ulam_pkg::LOSD_BIT+1] &&
      &core_tx_line_frame_overhead[ulam_pkg::LOSD_BIT-1:
      ulam_pkg::OH_FREE_LO]))
      else $error("unused overhead bit not one"); // RL15
   AST_FRAME: assert property (@(posedge sys_clk) disable iff (!resetn)
      fwrap |-> ((bidx_r + 8'(tick)) == 8'(ulam_pkg::FRAME_BYTES)))
      else $error("frame does not hold 144 bytes"); // RL13
   AST_DELAY: assert property (@(posedge sys_clk) disable iff (!resetn)
      wait_r < 16'(DLY))
      else $error("byte held beyond the unit delay budget"); // RL10 RL9
endmodule : ulam_mapper

// *** ulam_peer_model.sv ***
// peer transceiver model: feeds payload bytes and audits core frames
module ulam_peer_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // commands from the bench
   input wire logic [3:0] send_n,
   input wire logic [7:0] send_base,
   input wire logic send_go,
   input wire logic slow,
   // core frame from the design
   input wire logic [7:0] core_tx_byte,
   input wire logic core_tx_valid,
   input wire logic core_tx_sof,
   // payload towards the design
   output logic [7:0] core_rx_byte,
   output logic core_rx_valid,
   input wire logic core_rx_ready,
   // audit results
   output int frames,
   output int bad,
   output int nonff,
   output int zeros,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] left_r;
   logic [7:0] next_r;
   logic [1:0] gap_r;
   int idx_r;
   int pos;
   assign busy = (left_r != 4'h0);
   assign pos = core_tx_sof ? 0 : idx_r + 1;
   // offer a byte for one cycle, only once ready is seen high; the
   // design pushes on every valid edge, so holding valid would repeat it
   // idle bus toggles so no stale value shows
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         left_r <= 4'h0;
         gap_r <= 2'h0;
         core_rx_valid <= 1'b0;
         core_rx_byte <= 8'h00;
      end else if (send_go) begin
         left_r <= send_n;
         next_r <= send_base;
         core_rx_valid <= 1'b0;
      end else if (core_rx_valid) begin
         core_rx_valid <= 1'b0;
         core_rx_byte <= ~core_rx_byte;
         left_r <= left_r - 4'h1;
         next_r <= next_r + 8'h01;
         gap_r <= slow ? 2'h3 : 2'h0;
      end else if (gap_r != 2'h0) begin
         gap_r <= gap_r - 2'h1;
         core_rx_byte <= ~core_rx_byte;
      end else if (left_r != 4'h0 && core_rx_ready) begin
         core_rx_valid <= 1'b1;
         core_rx_byte <= next_r;
      end else begin
         core_rx_byte <= ~core_rx_byte;
      end
   end
   // audit slot positions, stuffing and payload bytes of each frame
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         idx_r <= 0;
         frames <= 0;
         bad <= 0;
         nonff <= 0;
         zeros <= 0;
      end else if (core_tx_valid) begin
         idx_r <= pos;
         if (core_tx_sof)
            frames <= frames + 1;
         if (core_tx_sof && frames > 0 && idx_r != 143)
            bad <= bad + 1;
         if (frames > 0 && pos % 9 == 8 && core_tx_byte != 8'hff)
            bad <= bad + 1;
         if (pos % 9 != 8 && core_tx_byte != 8'hff)
            nonff <= nonff + 1;
         if (pos % 9 != 8 && core_tx_byte == 8'h00)
            zeros <= zeros + 1;
      end
   end
endmodule : ulam_peer_model

// *** testbench.sv ***
// self-checking bench for the alarm mapper with a peer model
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   //------------------------------------------------------------------
   // signals and instances
   //------------------------------------------------------------------
   logic sys_clk = 1'b0, resetn = 1'b0, line_side = 1'b0;
   logic app_rx_clk = 1'b0, app_rx_data = 1'b1, far_los_or_lfa = 1'b0;
   logic other_fail = 1'b0, send_go = 1'b0, slow = 1'b0, src_en = 1'b1;
   logic cap_en = 1'b0, tx_q = 1'b0;
   logic [1:0] pair_active = 2'b11, pair_id_ok = 2'b11, pair_los = 2'b00;
   logic [1:0] pair_frame_alignment_loss = 2'b00;
   logic [3:0] send_n = 4'h0;
   logic [7:0] send_base = 8'h00, core_tx_byte, core_rx_byte;
   logic app_tx_clk, app_tx_data, core_tx_valid, core_tx_sof, busy;
   logic core_rx_valid, core_rx_ready, access_oper, app_los;
   logic alarm_indication_signal;
   logic [48:1] core_tx_line_frame_overhead;
   logic bits[$];
   int frames, bad, nonff, zeros, div = 0, zeros_left = 0, since_rise = 0;
   int mismatches = 0, total_checks = 0;
   ulam_mapper #(.NPAIRS(2), .FRAME_CYC(1440)) i_ulam_mapper (
      .sys_clk, .resetn, .line_side, .app_rx_clk, .app_rx_data,
      .app_tx_clk, .app_tx_data, .pair_active, .pair_id_ok, .pair_los,
      .pair_frame_alignment_loss, .far_los_or_lfa, .other_fail,
      .core_tx_byte, .core_tx_valid, .core_tx_sof,
      .core_tx_line_frame_overhead, .core_rx_byte, .core_rx_valid,
      .core_rx_ready, .access_oper, .app_los, .alarm_indication_signal);
   ulam_peer_model i_ulam_peer_model (
      .sys_clk, .resetn, .send_n, .send_base, .send_go, .slow,
      .core_tx_byte, .core_tx_valid, .core_tx_sof, .core_rx_byte,
      .core_rx_valid, .core_rx_ready, .frames, .bad, .nonff, .zeros,
      .busy);
   always #20 sys_clk = ~sys_clk;
   // application source: 12-cycle bits, ones unless zeros are queued
   always @(posedge sys_clk) begin
      since_rise <= (src_en && div == 6) ? 0 : since_rise + 1;
      if (src_en) begin
         div <= (div == 11) ? 0 : div + 1;
         if (div == 6)
            app_rx_clk <= 1'b1;
         if (div == 0) begin
            app_rx_clk <= 1'b0;
            app_rx_data <= (zeros_left == 0);
            if (zeros_left > 0)
               zeros_left <= zeros_left - 1;
         end
      end
   end
   // capture output bits mid-period, at the falling clock
   always @(posedge sys_clk) begin
      if (cap_en && tx_q && !app_tx_clk)
         bits.push_back(app_tx_data);
      tx_q <= app_tx_clk;
   end
   //------------------------------------------------------------------
   // tasks
   //------------------------------------------------------------------
   task automatic check(input string what, input logic [63:0] exp,
                        input logic [63:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run
   task automatic cycles(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cycles
   task automatic send(input logic [3:0] n, input logic [7:0] b,
                       input logic s);
      send_n <= n;
      send_base <= b;
      slow <= s;
      send_go <= 1'b1;
      @(posedge sys_clk);
      send_go <= 1'b0;
   endtask : send
   task automatic scen_oper();
      for (int k = 0; k < 7; k++) begin
         pair_active <= {k != 2, k != 1};
         pair_id_ok <= {k != 4, k != 3};
         other_fail <= (k == 5);
         cycles(3);
         check("access_oper", k == 0 || k == 6, access_oper);
      end
   endtask : scen_oper
   task automatic scen_tx();
      int z, n;
      for (n = 0; n < 100 && app_los !== 1'b0; n++)
         @(posedge sys_clk);
      check("app_los", 0, app_los);
      z = zeros;
      n = nonff;
      @(posedge sys_clk iff div == 3);
      zeros_left <= 24;
      cycles(3000);
      check("zero bytes", 1, zeros - z >= 2 && zeros - z <= 3);
      check("other bytes", 1, nonff - n <= zeros - z + 2);
      check("frames", 1, frames >= 2);
      check("frame audit", 0, bad);
      check("overhead", {48{1'b1}}, core_tx_line_frame_overhead);
   endtask : scen_tx
   task automatic scen_loss(input logic side);
      int n;
      logic [48:1] ovh;
      line_side <= side;
      @(posedge sys_clk iff div == 8);
      src_en <= 1'b0;
      for (n = 0; n < 300 && app_los !== 1'b1; n++)
         @(posedge sys_clk);
      check("los delay", 1, since_rise >= 200 && since_rise <= 210);
      @(posedge sys_clk);
      ovh = core_tx_line_frame_overhead;
      check("loss bit", 0, ovh[15]);
      ovh[15] = 1'b1;
      check("spare overhead", {48{1'b1}}, ovh);
      n = nonff;
      cycles(1500);
      check("payload in loss", n, nonff);
      src_en <= 1'b1;
      for (n = 0; n < 60 && app_los !== 1'b0; n++)
         @(posedge sys_clk);
      cycles(2);
      check("loss bit", 1, core_tx_line_frame_overhead[15]);
   endtask : scen_loss
   task automatic scen_alarm();
      int z;
      line_side <= 1'b1;
      for (int k = 0; k < 6; k++) begin
         pair_los <= {k == 1, k == 0};
         pair_frame_alignment_loss <= {k == 3, k == 2};
         far_los_or_lfa <= (k == 4);
         cycles(3);
         check("alarm", k != 5, alarm_indication_signal);
      end
      pair_los <= 2'b01;
      line_side <= 1'b0;
      cycles(3);
      check("customer alarm", 0, alarm_indication_signal);
      line_side <= 1'b1;
      bits.delete();
      cap_en <= 1'b1;
      send(4'h4, 8'h00, 1'b1);
      cycles(600);
      cap_en <= 1'b0;
      z = 0;
      foreach (bits[i])
         if (bits[i] !== 1'b1)
            z++;
      check("alarm bits", 1, bits.size() >= 40);
      check("alarm zeros", 0, z);
      pair_los <= 2'b00;
   endtask : scen_alarm
   task automatic scen_rx();
      int full, i0;
      logic ok;
      logic [7:0] e;
      cycles(800);
      bits.delete();
      cap_en <= 1'b1;
      send(4'hc, 8'h30, 1'b0);
      full = 0;
      for (int i = 0; i < 400 && (busy || i == 0); i++) begin
         @(posedge sys_clk);
         if (core_rx_ready === 1'b0)
            full++;
      end
      check("fifo refusal", 1, full > 0);
      cycles(1400);
      cap_en <= 1'b0;
      i0 = -1;
      foreach (bits[i])
         if (i0 < 0 && bits[i] === 1'b0)
            i0 = i;
      ok = (i0 >= 0) && (bits.size() >= i0 + 96);
      for (int b = 0; b < 96 && ok; b++) begin
         e = 8'h30 + 8'(b / 8);
         if (bits[i0 + b] !== e[7 - b % 8])
            ok = 1'b0;
      end
      check("rx bitstream", 1, ok);
   endtask : scen_rx
   task automatic scen_rate();
      int n;
      logic q;
      n = 0;
      q = app_tx_clk;
      repeat (1250) begin
         @(posedge sys_clk);
         if (app_tx_clk === 1'b1 && q === 1'b0)
            n++;
         q = app_tx_clk;
      end
      check("tx clock rises", 1, n >= 102 && n <= 103);
   endtask : scen_rate
   //------------------------------------------------------------------
   // main sequence and watchdog
   //------------------------------------------------------------------
   initial begin
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      cycles(2);
      scen_oper();
      scen_tx();
      scen_loss(1'b1);
      scen_loss(1'b0);
      scen_alarm();
      scen_rx();
      scen_rate();
      complete_run();
   end
   initial begin
      repeat (40000) @(posedge sys_clk);
      mismatches++;
      complete_run();
   end
endmodule : testbench
